// file: abie_regs.svh
// Register offsets, instruction field positions and reset values for the executor.
// Assumes a 32-bit AXI4-Lite register bus with byte addresses.
`ifndef ABIE_REGS_SVH
`define ABIE_REGS_SVH

// Byte offsets, one aligned word each
`define ABIE_OFF_INSTR 8'h00
`define ABIE_OFF_ACC 8'h04
`define ABIE_OFF_FLAGS 8'h08
`define ABIE_OFF_FADDR 8'h0c
`define ABIE_OFF_FDATA 8'h10

// Instruction word fields
`define ABIE_OP_MSB 14
`define ABIE_OP_LSB 12
`define ABIE_DEST_BIT 11
`define ABIE_BIDX_MSB 10
`define ABIE_BIDX_LSB 8
`define ABIE_ADDR_MSB 6

// Flag register bit positions
`define ABIE_FLAG_C 0
`define ABIE_FLAG_HC 1
`define ABIE_FLAG_Z 2
`define ABIE_FLAG_SKIP 3

// Reset values
`define ABIE_ACC_RST 8'h00
`define ABIE_FREG_RST 8'h00
`define ABIE_FADDR_RST 7'h00

// Bus responses
`define ABIE_RESP_OKAY 2'h0
`define ABIE_RESP_SLVERR 2'h2

`endif

// file: abie_pkg.sv
// Types shared by the executor and its arithmetic unit.
// Assumes nothing beyond a SystemVerilog compiler.
package abie_pkg;
   // Operation codes of the instruction word; all eight codes are legal
   typedef enum logic [2:0] {
      nop_op = 3'h0,
      add_immediate_op = 3'h1,
      add_register_op = 3'h2,
      and_immediate_op = 3'h3,
      and_register_op = 3'h4,
      bit_clear_op = 3'h5,
      bit_set_op = 3'h6,
      skip_if_bit_zero_op = 3'h7
   } abie_op_t;
endpackage

// file: abie_alu.sv
// Combinational arithmetic and bit unit of the executor.
// Assumes operands are stable for the cycle in which the result is stored.
`timescale 1ns/1ps
`default_nettype none
module abie_alu (
   // Operation and operands
   input wire abie_pkg::abie_op_t op_i,
   input wire logic [7:0] acc_i,
   input wire logic [7:0] freg_i,
   input wire logic [7:0] lit_i,
   input wire logic [2:0] bidx_i,
   // Result and flags
   output logic [7:0] res_o,
   output logic cy_o,
   output logic hc_o,
   output logic zero_o,
   output logic wr_c_o,
   output logic wr_z_o,
   output logic bit_o
);
   logic [8:0] sum; // Full sum with carry out of bit 7
   logic [4:0] nib; // Low nibble sum with carry out of bit 3
   logic [7:0] opnd; // Second operand: literal or file register
   logic [7:0] onehot; // Selected bit position

   // Operand choice, adders and the bit mask
   always_comb begin
      opnd = (op_i == abie_pkg::add_immediate_op || op_i == abie_pkg::and_immediate_op) ?
             lit_i : freg_i;
      sum = {1'b0, acc_i} + {1'b0, opnd};
      nib = {1'b0, acc_i[3:0]} + {1'b0, opnd[3:0]};
      onehot = 8'h01 << bidx_i;
      bit_o = freg_i[bidx_i];
      cy_o = sum[8];
      hc_o = nib[4];
   end

   // Result and which flags the operation may touch
   always_comb begin
      res_o = acc_i;
      wr_c_o = 1'b0;
      wr_z_o = 1'b0;
      unique case (op_i)
         abie_pkg::add_immediate_op, abie_pkg::add_register_op: begin
            res_o = sum[7:0];
            wr_c_o = 1'b1;
            wr_z_o = 1'b1;
         end
         abie_pkg::and_immediate_op, abie_pkg::and_register_op: begin
            res_o = acc_i & opnd;
            wr_z_o = 1'b1;
         end
         abie_pkg::bit_clear_op: res_o = freg_i & ~onehot;
         abie_pkg::bit_set_op: res_o = freg_i | onehot;
         abie_pkg::nop_op, abie_pkg::skip_if_bit_zero_op: res_o = acc_i;
      endcase
      zero_o = (res_o == 8'h00);
   end
endmodule
`default_nettype wire

// file: abie_exec.sv
// Instruction executor: accumulator, 128-entry file register space, flags, AXI4-Lite slave.
// Assumes all bus inputs come from logic on mclk_i; no synchronisers are needed.
`timescale 1ns/1ps
`default_nettype none
`include "abie_regs.svh"
module abie_exec (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // Write address channel
   input wire logic [7:0] awaddr_i,
   input wire logic awvalid_i,
   output logic awready_o,
   // Write data channel
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic wvalid_i,
   output logic wready_o,
   // Write response channel
   output logic [1:0] bresp_o,
   output logic bvalid_o,
   input wire logic bready_i,
   // Read address channel
   input wire logic [7:0] araddr_i,
   input wire logic arvalid_i,
   output logic arready_o,
   // Read data channel
   output logic [31:0] rdata_o,
   output logic [1:0] rresp_o,
   output logic rvalid_o,
   input wire logic rready_i
);
   // Bus slave state
   logic aw_held_q, w_held_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   // Datapath state
   logic [7:0] acc_q; // Accumulator
   logic [7:0] file_q [128]; // File register space
   logic [6:0] faddr_q; // Software pointer into the file space
   logic c_q, hc_q, z_q; // Carry, half_carry_flag, zero
   logic skip_q; // Next instruction is to be discarded
   logic [15:0] instr_q; // Last instruction word issued
   // Decoded write
   logic do_write, issue, go, sel_ok;
   abie_pkg::abie_op_t op;
   logic [6:0] fa;
   logic dest;
   logic [7:0] lit, freg, res;
   logic cy, hc, zero, wr_c, wr_z, tbit;
   logic to_acc, to_file;

   // A write fires once address and data are both held and no response is pending
   assign do_write = aw_held_q && w_held_q && !bvalid_q;
   assign issue = do_write && awaddr_q == `ABIE_OFF_INSTR && wstrb_q[1:0] == 2'h3;
   assign go = issue && !skip_q; // A discarded slot runs as a no-op
   assign op = abie_pkg::abie_op_t'(wdata_q[`ABIE_OP_MSB:`ABIE_OP_LSB]);
   assign fa = wdata_q[`ABIE_ADDR_MSB:0];
   assign dest = wdata_q[`ABIE_DEST_BIT];
   assign lit = wdata_q[7:0];
   assign freg = file_q[fa];
   assign to_acc = op == abie_pkg::add_immediate_op || op == abie_pkg::and_immediate_op ||
                   ((op == abie_pkg::add_register_op || op == abie_pkg::and_register_op) && !dest);
   assign to_file = op == abie_pkg::bit_clear_op || op == abie_pkg::bit_set_op ||
                    ((op == abie_pkg::add_register_op || op == abie_pkg::and_register_op) && dest);
   assign sel_ok = awaddr_q == `ABIE_OFF_INSTR || awaddr_q == `ABIE_OFF_ACC ||
                   awaddr_q == `ABIE_OFF_FLAGS || awaddr_q == `ABIE_OFF_FADDR ||
                   awaddr_q == `ABIE_OFF_FDATA;

   // Arithmetic and bit unit
   abie_alu u_alu (
      .op_i(op),
      .acc_i(acc_q),
      .freg_i(freg),
      .lit_i(lit),
      .bidx_i(wdata_q[`ABIE_BIDX_MSB:`ABIE_BIDX_LSB]),
      .res_o(res),
      .cy_o(cy),
      .hc_o(hc),
      .zero_o(zero),
      .wr_c_o(wr_c),
      .wr_z_o(wr_z),
      .bit_o(tbit)
   );

   // Write address capture; ready drops while an address is held
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         aw_held_q <= 1'b0;
         awready_q <= 1'b0;
         awaddr_q <= 8'h00;
      end else if (awvalid_i && awready_q) begin
         aw_held_q <= 1'b1;
         awready_q <= 1'b0;
         awaddr_q <= awaddr_i;
      end else if (do_write) begin
         aw_held_q <= 1'b0;
      end else if (!aw_held_q) begin
         awready_q <= 1'b1;
      end
   end

   // Write data capture, independent of the address
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         w_held_q <= 1'b0;
         wready_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (wvalid_i && wready_q) begin
         w_held_q <= 1'b1;
         wready_q <= 1'b0;
         wdata_q <= wdata_i;
         wstrb_q <= wstrb_i;
      end else if (do_write) begin
         w_held_q <= 1'b0;
      end else if (!w_held_q) begin
         wready_q <= 1'b1;
      end
   end

   // Write response, issued in the same edge that stores the result
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bvalid_q <= 1'b0;
         bresp_q <= `ABIE_RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         bresp_q <= sel_ok ? `ABIE_RESP_OKAY : `ABIE_RESP_SLVERR;
      end else if (bready_i) begin
         bvalid_q <= 1'b0;
      end
   end

   // Read channel: one cycle from address to data
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         rresp_q <= `ABIE_RESP_OKAY;
      end else if (arvalid_i && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rresp_q <= `ABIE_RESP_OKAY;
         unique case (araddr_i)
            `ABIE_OFF_INSTR: rdata_q <= {16'h0000, instr_q};
            `ABIE_OFF_ACC: rdata_q <= {24'h000000, acc_q};
            `ABIE_OFF_FLAGS: rdata_q <= {28'h0000000, skip_q, z_q, hc_q, c_q};
            `ABIE_OFF_FADDR: rdata_q <= {25'h0, faddr_q};
            `ABIE_OFF_FDATA: rdata_q <= {24'h000000, file_q[faddr_q]};
            default: begin
               rdata_q <= 32'h0000_0000;
               rresp_q <= `ABIE_RESP_SLVERR; // Unmapped address
            end
         endcase
      end else if (rvalid_q && rready_i) begin
         rvalid_q <= 1'b0;
      end else if (!rvalid_q) begin
         arready_q <= 1'b1;
      end
   end

   // Accumulator: instruction result or direct software write
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         acc_q <= `ABIE_ACC_RST;
      end else if (go && to_acc) begin
         acc_q <= res;
      end else if (do_write && awaddr_q == `ABIE_OFF_ACC && wstrb_q[0]) begin
         acc_q <= wdata_q[7:0];
      end
   end

   // File register space; instruction write-back or software data port
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         for (int i = 0; i < 128; i++) begin
            file_q[i] <= `ABIE_FREG_RST;
         end
      end else if (go && to_file) begin
         file_q[fa] <= res;
      end else if (do_write && awaddr_q == `ABIE_OFF_FDATA && wstrb_q[0]) begin
         file_q[faddr_q] <= wdata_q[7:0];
      end
   end

   // Software pointer and the record of the last instruction
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         faddr_q <= `ABIE_FADDR_RST;
         instr_q <= 16'h0000;
      end else if (issue) begin
         instr_q <= wdata_q[15:0];
      end else if (do_write && awaddr_q == `ABIE_OFF_FADDR && wstrb_q[0]) begin
         faddr_q <= wdata_q[`ABIE_ADDR_MSB:0];
      end
   end

   // Status flags; bit operations and tests leave them alone
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         c_q <= 1'b0;
         hc_q <= 1'b0;
         z_q <= 1'b0;
      end else if (go) begin
         if (wr_c) begin
            c_q <= cy;
            hc_q <= hc;
         end
         if (wr_z) begin
            z_q <= zero;
         end
      end else if (do_write && awaddr_q == `ABIE_OFF_FLAGS && wstrb_q[0]) begin
         c_q <= wdata_q[`ABIE_FLAG_C];
         hc_q <= wdata_q[`ABIE_FLAG_HC];
         z_q <= wdata_q[`ABIE_FLAG_Z];
      end
   end

   // Skip: a zero test bit discards exactly the next issued instruction
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         skip_q <= 1'b0;
      end else if (issue) begin
         skip_q <= go && op == abie_pkg::skip_if_bit_zero_op && !tbit;
      end
   end

   // Outputs straight from flops
   assign awready_o = awready_q;
   assign wready_o = wready_q;
   assign bvalid_o = bvalid_q;
   assign bresp_o = bresp_q;
   assign arready_o = arready_q;
   assign rvalid_o = rvalid_q;
   assign rdata_o = rdata_q;
   assign rresp_o = rresp_q;

   // Checks on the executed instructions
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_run(abie_pkg::abie_op_t o);
      go && op == o;
   endsequence
   sequence s_skip_armed;
      go && op == abie_pkg::skip_if_bit_zero_op && !tbit;
   endsequence

   a_add_imm_sum: assert property (s_run(abie_pkg::add_immediate_op) |=>
      {c_q, acc_q} == 9'({1'b0, $past(acc_q)} + {1'b0, $past(lit)}))
      else $error("add immediate result or carry wrong");
   a_add_reg_dest: assert property (s_run(abie_pkg::add_register_op) ##0 dest |=>
      file_q[$past(fa)] == 8'($past(acc_q) + $past(freg)) && $stable(acc_q))
      else $error("add register to file wrong");
   a_and_imm_flags: assert property (s_run(abie_pkg::and_immediate_op) |=>
      acc_q == ($past(acc_q) & $past(lit)) && $stable(c_q) && $stable(hc_q))
      else $error("and immediate wrong or carry changed");
   a_and_reg_dest: assert property (s_run(abie_pkg::and_register_op) ##0 !dest |=>
      acc_q == ($past(acc_q) & $past(freg)) && z_q == (acc_q == 8'h00))
      else $error("and register to accumulator wrong");
   a_bit_clear: assert property (s_run(abie_pkg::bit_clear_op) |=>
      file_q[$past(fa)] == ($past(freg) & ~(8'h01 << $past(wdata_q[10:8])))
      && $stable(z_q) && $stable(c_q))
      else $error("bit clear wrong");
   a_bit_set: assert property (s_run(abie_pkg::bit_set_op) |=>
      file_q[$past(fa)] == ($past(freg) | (8'h01 << $past(wdata_q[10:8]))) && $stable(hc_q))
      else $error("bit set wrong");
   a_skip_not_taken: assert property (s_run(abie_pkg::skip_if_bit_zero_op) ##0 tbit |=>
      !skip_q && $stable(acc_q) && $stable(z_q))
      else $error("skip taken on a set bit");
   a_skip_armed: assert property (s_skip_armed |=> skip_q)
      else $error("skip not armed on a clear bit");
   a_skip_discard: assert property (issue && skip_q |=>
      !skip_q && $stable(acc_q) && $stable(c_q) && $stable(z_q))
      else $error("discarded instruction had an effect");
   a_half_carry: assert property (go && wr_c |=>
      hc_q == ($past(res[3:0]) < $past(acc_q[3:0])))
      else $error("half carry flag wrong");
   a_one_cycle: assert property (do_write |=> bvalid_q && !aw_held_q && !w_held_q)
      else $error("write did not complete in one cycle");
endmodule
`default_nettype wire

// file: alu_bit_instr_exec_tb.sv
// Self-checking bench for the executor: AXI4-Lite tasks and instruction sequences.
// Assumes abie_pkg, abie_alu and abie_exec are compiled first; one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
`include "abie_regs.svh"
module alu_bit_instr_exec_tb;
   // Clock, reset and bus drive
   logic mclk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   // Design answers
   logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
   logic [1:0] bresp_o, rresp_o;
   logic [31:0] rdata_o;
   // Result counters
   int num_errors = 0;
   int n_tests = 0;

   // Free-running clock, 10 ns period
   always #5 mclk_i = ~mclk_i;

   abie_exec DUT (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .awaddr_i(awaddr), .awvalid_i(awvalid),
      .awready_o(awready_o), .wdata_i(wdata), .wstrb_i(wstrb), .wvalid_i(wvalid),
      .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready),
      .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(arready_o), .rdata_o(rdata_o),
      .rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready));

   // Counts, verdict and end of run
   task automatic test_done();
      $display("Checks %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // One compare for every bus value
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // A wait that runs out counts a mismatch and ends the run
   task automatic hang(input string nm);
      num_errors++;
      $display("ERROR %s expected answer seen none", nm);
      test_done();
   endtask

   // Write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit done;
      done = 0;
      @(posedge mclk_i);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= 4'hf;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int i = 0; i < 100 && !done; i++) begin
         @(posedge mclk_i);
         if (awvalid && awready_o === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready_o === 1'b1) wvalid <= 1'b0;
         if (bvalid_o === 1'b1) begin
            r = bresp_o;
            bready <= 1'b0;
            done = 1;
         end
      end
      if (!done) hang("bvalid");
   endtask

   // Read and compare data and response
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      bit done;
      logic [31:0] d;
      logic [1:0] r;
      done = 0;
      @(posedge mclk_i);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int i = 0; i < 100 && !done; i++) begin
         @(posedge mclk_i);
         if (arvalid && arready_o === 1'b1) arvalid <= 1'b0;
         if (rvalid_o === 1'b1) begin
            d = rdata_o;
            r = rresp_o;
            rready <= 1'b0;
            done = 1;
         end
      end
      if (!done) hang("rvalid");
      chk("rdata", e, d);
      chk("rresp", {30'h0, er}, {30'h0, r});
   endtask

   // Instruction word: op, destination, bit index, literal or file address
   function automatic logic [31:0] mk(input abie_pkg::abie_op_t op, input logic dst,
      input logic [2:0] b, input logic [7:0] k);
      mk = {17'h0, op, dst, b, k};
   endfunction

   // Preset file register, accumulator and flags, issue one word, check all three
   task automatic run(input logic [7:0] a0, f0, g0, input logic [31:0] ins,
      input logic [7:0] ea, eg, ef);
      logic [1:0] r;
      wr(`ABIE_OFF_FADDR, {25'h0, ins[6:0]}, r);
      wr(`ABIE_OFF_FDATA, {24'h0, f0}, r);
      wr(`ABIE_OFF_ACC, {24'h0, a0}, r);
      wr(`ABIE_OFF_FLAGS, {24'h0, g0}, r);
      wr(`ABIE_OFF_INSTR, ins, r);
      chk("instr bresp", {30'h0, `ABIE_RESP_OKAY}, {30'h0, r});
      // Read straight after the response: the word has already completed
      rchk(`ABIE_OFF_ACC, {24'h0, ea}, `ABIE_RESP_OKAY);
      rchk(`ABIE_OFF_FLAGS, {24'h0, eg}, `ABIE_RESP_OKAY);
      rchk(`ABIE_OFF_FDATA, {24'h0, ef}, `ABIE_RESP_OKAY);
   endtask

   // Reset values of every register that the bus reaches except the instruction word
   task automatic reset_vals();
      rchk(`ABIE_OFF_ACC, 32'h0, `ABIE_RESP_OKAY);
      rchk(`ABIE_OFF_FLAGS, 32'h0, `ABIE_RESP_OKAY);
      rchk(`ABIE_OFF_FADDR, 32'h0, `ABIE_RESP_OKAY);
      rchk(`ABIE_OFF_FDATA, 32'h0, `ABIE_RESP_OKAY);
   endtask

   // Main sequence
   initial begin
      logic [1:0] r;
      repeat (8) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      reset_vals();
      // Unmapped place: write refused, read gives zero
      wr(8'h14, 32'h5a, r);
      chk("unmapped bresp", {30'h0, `ABIE_RESP_SLVERR}, {30'h0, r});
      rchk(8'h14, 32'h0, `ABIE_RESP_SLVERR);
      $display("Test reset and unmapped done");
      // Adds: carry out of bit 3 and bit 7, zero result, all flags cleared
      run(8'h0f, 8'h00, 8'h00, mk(abie_pkg::add_immediate_op, 0, 0, 8'h01), 8'h10, 8'h02, 8'h00);
      run(8'hff, 8'h00, 8'h00, mk(abie_pkg::add_immediate_op, 0, 0, 8'h01), 8'h00, 8'h07, 8'h00);
      run(8'h80, 8'h00, 8'h07, mk(abie_pkg::add_immediate_op, 0, 0, 8'h7f), 8'hff, 8'h00, 8'h00);
      run(8'h88, 8'h88, 8'h00, mk(abie_pkg::add_register_op, 0, 0, 8'h7f), 8'h10, 8'h03, 8'h88);
      run(8'h01, 8'h02, 8'h07, mk(abie_pkg::add_register_op, 1, 0, 8'h00), 8'h01, 8'h00, 8'h03);
      // ANDs: carry and half carry left alone
      run(8'hf0, 8'h00, 8'h03, mk(abie_pkg::and_immediate_op, 0, 0, 8'h0f), 8'h00, 8'h07, 8'h00);
      run(8'hf0, 8'h00, 8'h04, mk(abie_pkg::and_immediate_op, 0, 0, 8'h3c), 8'h30, 8'h00, 8'h00);
      run(8'haa, 8'h0f, 8'h07, mk(abie_pkg::and_register_op, 1, 0, 8'h55), 8'haa, 8'h03, 8'h0a);
      run(8'h55, 8'haa, 8'h00, mk(abie_pkg::and_register_op, 0, 0, 8'h55), 8'h00, 8'h04, 8'haa);
      rchk(`ABIE_OFF_INSTR, mk(abie_pkg::and_register_op, 0, 0, 8'h55), `ABIE_RESP_OKAY);
      // No-operation word with the file destination set: nothing may change
      run(8'h33, 8'h5a, 8'h07, mk(abie_pkg::nop_op, 1, 0, 8'h10), 8'h33, 8'h07, 8'h5a);
      $display("Test arithmetic done");
      // Bit operations at both ends of the index, flags untouched
      run(8'h33, 8'hff, 8'h07, mk(abie_pkg::bit_clear_op, 0, 7, 8'h40), 8'h33, 8'h07, 8'h7f);
      run(8'h33, 8'hff, 8'h00, mk(abie_pkg::bit_clear_op, 0, 0, 8'h7f), 8'h33, 8'h00, 8'hfe);
      run(8'h33, 8'h00, 8'h07, mk(abie_pkg::bit_set_op, 0, 0, 8'h00), 8'h33, 8'h07, 8'h01);
      run(8'h33, 8'h00, 8'h00, mk(abie_pkg::bit_set_op, 0, 7, 8'h40), 8'h33, 8'h00, 8'h80);
      $display("Test bit operations done");
      // Tested bit one: no skip, next word runs
      run(8'h11, 8'h08, 8'h00, mk(abie_pkg::skip_if_bit_zero_op, 0, 3, 8'h21), 8'h11, 8'h00, 8'h08);
      run(8'h11, 8'h22, 8'h00, mk(abie_pkg::add_immediate_op, 0, 0, 8'h01), 8'h12, 8'h00, 8'h22);
      // Tested bit zero: skip pending survives other writes, next word discarded
      run(8'h11, 8'hf7, 8'h05, mk(abie_pkg::skip_if_bit_zero_op, 0, 3, 8'h21), 8'h11, 8'h0d, 8'hf7);
      run(8'h11, 8'h00, 8'h00, mk(abie_pkg::add_immediate_op, 0, 0, 8'hff), 8'h11, 8'h00, 8'h00);
      run(8'h11, 8'h00, 8'h00, mk(abie_pkg::add_immediate_op, 0, 0, 8'hff), 8'h10, 8'h03, 8'h00);
      $display("Test skip done");
      // Second reset in mid-run clears what was written
      @(posedge mclk_i);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      reset_vals();
      $display("Test second reset done");
      test_done();
   end
endmodule
`default_nettype wire
